// ===== src/pmrc_regs.vh
// register map, field positions, reset values and timing counts of the power and reset block
`ifndef PMRC_REGS_VH
`define PMRC_REGS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PMRC_POWER_CONTROL_REG_OFF 8'h00
`define PMRC_AUX_OFF 8'h04
`define PMRC_STAT_OFF 8'h08
`define PMRC_WATCHDOG_CONTROL_OFF 8'hD8

// ----------------------------------------
// power control fields
// ----------------------------------------
`define PMRC_PC_IDLE 0
`define PMRC_PC_PD 1

// ----------------------------------------
// auxiliary control fields
// ----------------------------------------
`define PMRC_AUX_SOFTWARE_RESET_BIT 0
`define PMRC_AUX_POR 1
`define PMRC_AUX_LOW_POWER_BROWNOUT_BIT 2
`define PMRC_AUX_BOD 3

// ----------------------------------------
// watchdog control fields
// ----------------------------------------
`define PMRC_WD_CLR 0
`define PMRC_WD_WATCHDOG_RESET_ENABLE 1
`define PMRC_WD_WATCHDOG_RESET_CAUSE_FLAG 2
`define PMRC_WD_WATCHDOG_TIMEOUT_FLAG 3
`define PMRC_WD_WD0 4
`define PMRC_WD_WD1 5
`define PMRC_WD_RUN 7

// ----------------------------------------
// reset values
// ----------------------------------------
`define PMRC_RST_PC 16'h0000
`define PMRC_RST_SP 8'h07
`define PMRC_RST_PORT 8'hFF

// ----------------------------------------
// timing counts: pin lows in machine cycles, the others in clock periods
// ----------------------------------------
`define PMRC_PIN_LOW_SAMPLES 2'h2
`define PMRC_RST_HOLD_CLKS 4'h8
`define PMRC_WDT_RST_DLY 10'h200

// ----------------------------------------
// bus answers
// ----------------------------------------
`define PMRC_RESP_OKAY 2'h0
`define PMRC_RESP_SLVERR 2'h2

`endif

// ===== src/pmrc_top.v
// power mode and reset control with an AXI4-Lite register port
// Overview of operation
// - power control bit 0 enters idle
// - idle stops cpu clock, freezes core and pins
// - enabled interrupt clears idle bit and wakes
// - pin sampled at fourth state, two lows
// - reset gives pc 0000h, no oscillator delay
// - watchdog timeout flag; reset 512 clocks later
// - watchdog reset held two machine cycles
// - reset exit from idle skips next instruction
// - power control bit 1 stops cpu and peripheral clocks
// - reset pin low ends power-down
// - externally clocked watchdog stops in power-down
// - power-down wake sources, adc needs rc clock
// - enabled external interrupt wakes from power-down
// - rc clock on in power-down when low_power_brownout_bit set, bod clear
// - reset held two machine cycles after the source ends
// - no flag for external pin reset
// - power-on delay sets flag, software clears
// - software reset bit resets the device
// - ram kept, stack pointer to 07h
// - ports ffh, watchdog off after power-on
// - watchdog_reset_cause_flag set by watchdog, watchdog_reset_enable cleared always
// - watchdog clear restarts count, timeout sets flag
`timescale 1ns/1ps
`include "pmrc_regs.vh"

module pmrc_top #(
	parameter POR_DELAY_CLKS = 1024,
	parameter WDT_INTERVAL = 131072,
	parameter WDT_CNT_W = 20
) (
	// clock and reset
	input wire CLK,
	input wire SYS_RST,
	// axi4-lite write address
	input wire [7:0] S_AXI_AWADDR,
	input wire S_AXI_AWVALID,
	output reg S_AXI_AWREADY,
	// axi4-lite write data
	input wire [31:0] S_AXI_WDATA,
	input wire [3:0] S_AXI_WSTRB,
	input wire S_AXI_WVALID,
	output reg S_AXI_WREADY,
	// axi4-lite write response
	output reg [1:0] S_AXI_BRESP,
	output reg S_AXI_BVALID,
	input wire S_AXI_BREADY,
	// axi4-lite read
	input wire [7:0] S_AXI_ARADDR,
	input wire S_AXI_ARVALID,
	output reg S_AXI_ARREADY,
	output reg [31:0] S_AXI_RDATA,
	output reg [1:0] S_AXI_RRESP,
	output reg S_AXI_RVALID,
	input wire S_AXI_RREADY,
	// reset sources
	input wire RST_N_PIN,
	input wire POWER_GOOD,
	input wire BROWNOUT_DET,
	// wake-up sources
	input wire IRQ_PENDING,
	input wire WDT_INT_EN,
	input wire GLOBAL_INT_ENABLE,
	input wire [1:0] EXT_INT_N,
	input wire [1:0] EXT_INT_EN,
	input wire KEYPAD_INTERRUPT,
	input wire ADC_BUSY,
	input wire ADC_DONE,
	input wire RC_CLK_SEL,
	input wire WDT_CLK_EXT,
	// clock gating and core control
	output reg CPU_CLK_EN,
	output reg PERIPH_CLK_EN,
	output reg RC_CLK_EN,
	output reg PORT_FREEZE,
	output reg WAKE_ISR,
	output reg CORE_RST,
	output reg WDT_TIMEOUT_FLAG,
	output reg [15:0] RESET_PC,
	output reg [7:0] RESET_SP,
	output reg [7:0] RESET_PORT
);

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	function hit;
		input [7:0] addr;
		input [7:0] off;
		begin
			hit = (addr[7:2] == off[7:2]);
		end
	endfunction

	function mapped;
		input [7:0] addr;
		begin
			mapped = hit(addr, `PMRC_POWER_CONTROL_REG_OFF) | hit(addr, `PMRC_AUX_OFF) |
				hit(addr, `PMRC_STAT_OFF) | hit(addr, `PMRC_WATCHDOG_CONTROL_OFF);
		end
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	reg [1:0] phase;
	reg [1:0] pin_lows;
	reg [3:0] hold_cnt;
	reg [31:0] por_cnt;
	reg idle;
	reg pdown;
	reg software_reset_bit;
	reg por_flag;
	reg low_power_brownout_bit;
	reg brownout_disable_bit;
	reg wd_run;
	reg wd1;
	reg wd0;
	reg watchdog_timeout_flag;
	reg watchdog_reset_cause_flag;
	reg watchdog_reset_enable;
	reg [WDT_CNT_W-1:0] wdt_cnt;
	reg dly_on;
	reg [9:0] dly_cnt;
	reg wdt_fire;
	reg adc_armed;
	reg [1:0] ext_prev_n;
	reg aw_got;
	reg w_got;
	reg [7:0] aw_addr;
	reg [7:0] w_data;
	reg w_lane0;

	wire c4 = (phase == 2'h3);
	wire ext_req = (pin_lows == `PMRC_PIN_LOW_SAMPLES);
	wire por_active = (por_cnt != 32'h0);
	wire bor_req = BROWNOUT_DET & ~brownout_disable_bit;
	// every source lands here; reset applies on the next edge
	wire src_any = ext_req | wdt_fire | software_reset_bit | bor_req | por_active;
	wire do_wr = aw_got & w_got & ~S_AXI_BVALID;
	wire wr_ok = do_wr & w_lane0 & mapped(aw_addr);
	wire wr_power_control_reg = wr_ok & hit(aw_addr, `PMRC_POWER_CONTROL_REG_OFF);
	wire wr_aux = wr_ok & hit(aw_addr, `PMRC_AUX_OFF);
	wire wr_wd = wr_ok & hit(aw_addr, `PMRC_WATCHDOG_CONTROL_OFF);
	wire wd_clr = wr_wd & w_data[`PMRC_WD_CLR];
	// an externally clocked watchdog has no clock in power-down
	wire wdt_go = wd_run & ~(pdown & WDT_CLK_EXT);
	wire wdt_hit = wdt_go & (wdt_cnt == WDT_INTERVAL[WDT_CNT_W-1:0] - 1'b1);
	wire idle_wake = idle & (IRQ_PENDING | (watchdog_timeout_flag & WDT_INT_EN));

	// ----------------------------------------
	// external interrupt wake per pin
	// ----------------------------------------
	wire [1:0] ext_wake;
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_ext
			// low level or falling edge, gated by both enables
			assign ext_wake[gi] = EXT_INT_EN[gi] & GLOBAL_INT_ENABLE &
				(~EXT_INT_N[gi] | (ext_prev_n[gi] & ~EXT_INT_N[gi]));
		end
	endgenerate

	wire pd_wake = pdown & ((|ext_wake) | KEYPAD_INTERRUPT | (adc_armed & ADC_DONE));

	// ----------------------------------------
	// machine cycle and reset merge
	// ----------------------------------------
	always @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			phase <= 2'h0;
			pin_lows <= 2'h0;
			hold_cnt <= 4'h0;
			por_cnt <= 32'h1;
			CORE_RST <= 1'b1;
			ext_prev_n <= 2'h3;
		end else begin
			phase <= phase + 2'h1;
			ext_prev_n <= EXT_INT_N;
			if (c4) begin
				if (!RST_N_PIN) begin
					if (!ext_req)
						pin_lows <= pin_lows + 2'h1;
				end else begin
					pin_lows <= 2'h0;
				end
			end
			// power loss restarts the power-on delay
			if (!POWER_GOOD)
				por_cnt <= POR_DELAY_CLKS;
			else if (por_active)
				por_cnt <= por_cnt - 32'h1;
			if (src_any)
				hold_cnt <= `PMRC_RST_HOLD_CLKS;
			else if (hold_cnt != 4'h0)
				hold_cnt <= hold_cnt - 4'h1;
			CORE_RST <= src_any | (hold_cnt != 4'h0);
		end
	end

	// ----------------------------------------
	// power control and auxiliary control
	// ----------------------------------------
	always @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			idle <= 1'b0;
			pdown <= 1'b0;
			software_reset_bit <= 1'b0;
			por_flag <= 1'b0;
			low_power_brownout_bit <= 1'b0;
			brownout_disable_bit <= 1'b0;
			adc_armed <= 1'b0;
			WAKE_ISR <= 1'b0;
		end else begin
			WAKE_ISR <= idle_wake | pd_wake;
			// reset also ends idle, so the core restarts at the reset address
			if (src_any) begin
				idle <= 1'b0;
				pdown <= 1'b0;
				software_reset_bit <= 1'b0;
				low_power_brownout_bit <= 1'b0;
				brownout_disable_bit <= 1'b0;
				adc_armed <= 1'b0;
			end else begin
				if (idle_wake)
					idle <= 1'b0;
				if (pd_wake)
					pdown <= 1'b0;
				if (wr_power_control_reg) begin
					if (w_data[`PMRC_PC_IDLE])
						idle <= 1'b1;
					if (w_data[`PMRC_PC_PD]) begin
						pdown <= 1'b1;
						adc_armed <= ADC_BUSY & RC_CLK_SEL;
					end
				end
				if (wr_aux) begin
					software_reset_bit <= w_data[`PMRC_AUX_SOFTWARE_RESET_BIT];
					low_power_brownout_bit <= w_data[`PMRC_AUX_LOW_POWER_BROWNOUT_BIT];
					brownout_disable_bit <= w_data[`PMRC_AUX_BOD];
				end
			end
			// power-on sets the flag and wins over a clearing write
			if (por_active)
				por_flag <= 1'b1;
			else if (wr_aux)
				por_flag <= w_data[`PMRC_AUX_POR];
		end
	end

	// ----------------------------------------
	// watchdog
	// ----------------------------------------
	always @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			wd_run <= 1'b0;
			wd1 <= 1'b0;
			wd0 <= 1'b0;
			watchdog_timeout_flag <= 1'b0;
			watchdog_reset_cause_flag <= 1'b0;
			watchdog_reset_enable <= 1'b0;
			wdt_cnt <= {WDT_CNT_W{1'b0}};
			dly_on <= 1'b0;
			dly_cnt <= 10'h0;
			wdt_fire <= 1'b0;
		end else begin
			wdt_fire <= 1'b0;
			if (src_any) begin
				if (por_active) begin
					wd_run <= 1'b0;
					wd1 <= 1'b0;
					wd0 <= 1'b0;
					watchdog_reset_cause_flag <= 1'b0;
				end else if (wdt_fire) begin
					watchdog_reset_cause_flag <= 1'b1;
				end
				watchdog_reset_enable <= 1'b0;
				watchdog_timeout_flag <= 1'b0;
				wdt_cnt <= {WDT_CNT_W{1'b0}};
				dly_on <= 1'b0;
				dly_cnt <= 10'h0;
			end else begin
				if (wr_wd) begin
					wd_run <= w_data[`PMRC_WD_RUN];
					wd1 <= w_data[`PMRC_WD_WD1];
					wd0 <= w_data[`PMRC_WD_WD0];
					watchdog_reset_enable <= w_data[`PMRC_WD_WATCHDOG_RESET_ENABLE];
					watchdog_reset_cause_flag <= w_data[`PMRC_WD_WATCHDOG_RESET_CAUSE_FLAG];
				end
				// timeout sets the flag even against a clearing write
				if (wdt_hit)
					watchdog_timeout_flag <= 1'b1;
				else if (wr_wd)
					watchdog_timeout_flag <= w_data[`PMRC_WD_WATCHDOG_TIMEOUT_FLAG];
				if (wd_clr || wdt_hit)
					wdt_cnt <= {WDT_CNT_W{1'b0}};
				else if (wdt_go)
					wdt_cnt <= wdt_cnt + 1'b1;
				// clearing the counter or any reset source cancels a pending reset
				if (wd_clr) begin
					dly_on <= 1'b0;
				end else if (wdt_hit && watchdog_reset_enable && !dly_on) begin
					dly_on <= 1'b1;
					dly_cnt <= 10'h0;
				end else if (dly_on && wdt_go) begin
					if (dly_cnt == `PMRC_WDT_RST_DLY - 10'h1) begin
						dly_on <= 1'b0;
						wdt_fire <= 1'b1;
					end else begin
						dly_cnt <= dly_cnt + 10'h1;
					end
				end
			end
		end
	end

	// ----------------------------------------
	// clock gating and reset value outputs
	// ----------------------------------------
	always @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			CPU_CLK_EN <= 1'b1;
			PERIPH_CLK_EN <= 1'b1;
			RC_CLK_EN <= 1'b0;
			PORT_FREEZE <= 1'b0;
			WDT_TIMEOUT_FLAG <= 1'b0;
			RESET_PC <= `PMRC_RST_PC;
			RESET_SP <= `PMRC_RST_SP;
			RESET_PORT <= `PMRC_RST_PORT;
		end else begin
			CPU_CLK_EN <= ~(idle | pdown);
			PERIPH_CLK_EN <= ~pdown;
			RC_CLK_EN <= pdown & low_power_brownout_bit & ~brownout_disable_bit;
			PORT_FREEZE <= idle;
			WDT_TIMEOUT_FLAG <= watchdog_timeout_flag;
			// ram has no reset path here; only pc, sp and ports are forced
			RESET_PC <= `PMRC_RST_PC;
			RESET_SP <= `PMRC_RST_SP;
			RESET_PORT <= `PMRC_RST_PORT;
		end
	end

	// ----------------------------------------
	// axi4-lite write channel
	// ----------------------------------------
	always @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 8'h00;
			w_lane0 <= 1'b0;
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY <= 1'b0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= `PMRC_RESP_OKAY;
		end else begin
			S_AXI_AWREADY <= ~aw_got & ~(S_AXI_AWVALID & S_AXI_AWREADY) & ~S_AXI_BVALID;
			S_AXI_WREADY <= ~w_got & ~(S_AXI_WVALID & S_AXI_WREADY) & ~S_AXI_BVALID;
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_got <= 1'b1;
				aw_addr <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_got <= 1'b1;
				w_data <= S_AXI_WDATA[7:0];
				w_lane0 <= S_AXI_WSTRB[0];
			end
			if (do_wr) begin
				aw_got <= 1'b0;
				w_got <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= mapped(aw_addr) ? `PMRC_RESP_OKAY : `PMRC_RESP_SLVERR;
			end else if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// axi4-lite read channel
	// ----------------------------------------
	reg [7:0] rd_byte;
	always @* begin
		rd_byte = 8'h00;
		if (hit(S_AXI_ARADDR, `PMRC_POWER_CONTROL_REG_OFF))
			rd_byte = {6'h00, pdown, idle};
		else if (hit(S_AXI_ARADDR, `PMRC_AUX_OFF))
			rd_byte = {4'h0, brownout_disable_bit, low_power_brownout_bit, por_flag, software_reset_bit};
		else if (hit(S_AXI_ARADDR, `PMRC_STAT_OFF))
			rd_byte = {5'h00, CORE_RST, pdown, idle};
		else if (hit(S_AXI_ARADDR, `PMRC_WATCHDOG_CONTROL_OFF))
			rd_byte = {wd_run, 1'b0, wd1, wd0, watchdog_timeout_flag, watchdog_reset_cause_flag, watchdog_reset_enable, 1'b0};
	end

	always @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h00000000;
			S_AXI_RRESP <= `PMRC_RESP_OKAY;
		end else begin
			S_AXI_ARREADY <= ~S_AXI_RVALID & ~(S_AXI_ARVALID & S_AXI_ARREADY);
			if (S_AXI_ARVALID && S_AXI_ARREADY) begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RDATA <= {24'h000000, rd_byte};
				S_AXI_RRESP <= mapped(S_AXI_ARADDR) ? `PMRC_RESP_OKAY : `PMRC_RESP_SLVERR;
			end else if (S_AXI_RVALID && S_AXI_RREADY) begin
				S_AXI_RVALID <= 1'b0;
			end
		end
	end

endmodule // pmrc_top

// ===== test/pmrc_checker.sv
// port assertions for the power mode and reset block
`timescale 1ns/1ps
module pmrc_checker (
	// clock and reset
	input wire CLK,
	input wire SYS_RST,
	// sources
	input wire RST_N_PIN,
	input wire IRQ_PENDING,
	input wire GLOBAL_INT_ENABLE,
	input wire [1:0] EXT_INT_N,
	input wire [1:0] EXT_INT_EN,
	// control outputs
	input wire CPU_CLK_EN,
	input wire PERIPH_CLK_EN,
	input wire RC_CLK_EN,
	input wire PORT_FREEZE,
	input wire WAKE_ISR,
	input wire CORE_RST,
	input wire [15:0] RESET_PC,
	input wire [7:0] RESET_SP,
	input wire [7:0] RESET_PORT
);
	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);

	a_reset_vals: assert property (
		RESET_PC == 16'h0000 && RESET_SP == 8'h07 && RESET_PORT == 8'hFF)
		else $error("reset load values wrong");
	a_freeze_idle: assert property (PORT_FREEZE |-> !CPU_CLK_EN)
		else $error("pins frozen while cpu clock runs");
	a_pd_clocks: assert property (!PERIPH_CLK_EN |-> !CPU_CLK_EN)
		else $error("cpu clock runs in power-down");
	a_rc_pd: assert property (RC_CLK_EN |-> !PERIPH_CLK_EN)
		else $error("rc clock on outside power-down");
	a_idle_wake: assert property (
		(PORT_FREEZE && IRQ_PENDING && !CORE_RST) |-> ##[1:3] CPU_CLK_EN)
		else $error("interrupt did not end idle");
	a_ext_wake: assert property (
		(!PERIPH_CLK_EN && GLOBAL_INT_ENABLE && EXT_INT_EN[0] && !EXT_INT_N[0])
		|-> ##[1:3] PERIPH_CLK_EN) else $error("external pin did not end power-down");
	a_pin_rst: assert property ((!RST_N_PIN) [*8] |-> ##[1:3] CORE_RST)
		else $error("long pin low gave no reset");
	a_rst_hold: assert property (
		$fell(CORE_RST) |-> $past(CORE_RST, 8) && $past(CORE_RST, 4))
		else $error("core reset shorter than two machine cycles");
	a_rst_clocks: assert property (
		CORE_RST |-> ##[0:2] (CPU_CLK_EN && PERIPH_CLK_EN))
		else $error("clocks stopped during reset");
	a_wake_idle: assert property (
		($fell(PORT_FREEZE) && !CORE_RST) |-> $past(WAKE_ISR))
		else $error("idle ended without wake pulse");
	a_wake_pd: assert property (
		($rose(PERIPH_CLK_EN) && !CORE_RST) |-> $past(WAKE_ISR))
		else $error("power-down ended without wake pulse");
endmodule // pmrc_checker

// ===== test/pmrc_wake_src.sv
// reset pin and wake-up sources outside the block
`timescale 1ns/1ps
module pmrc_wake_src (
	// clock
	input wire clk,
	// driven lines
	output reg rst_n = 1'b1,
	output reg [1:0] ext_n = 2'h3,
	output reg irq = 1'b0,
	output reg kbd = 1'b0,
	output reg adc_done = 1'b0
);
	// long holds keep the pin request valid
	task pin_low(input integer n);
		begin
			@(posedge clk);
			rst_n <= 1'b0;
			repeat (n) @(posedge clk);
			rst_n <= 1'b1;
		end
	endtask

	// 0 irq, 1 ext pin 0, 2 keypad, 3 adc done
	task pulse(input integer k, input integer n);
		begin
			@(posedge clk);
			case (k)
				0: irq <= 1'b1;
				1: ext_n <= 2'h2;
				2: kbd <= 1'b1;
				default: adc_done <= 1'b1;
			endcase
			repeat (n) @(posedge clk);
			irq <= 1'b0;
			ext_n <= 2'h3;
			kbd <= 1'b0;
			adc_done <= 1'b0;
		end
	endtask
endmodule // pmrc_wake_src

// ===== test/pmrc_top_test.sv
// self-checking bench for the power mode and reset block
`timescale 1ns/1ps
`include "pmrc_regs.vh"
module pmrc_top_test;
	reg clk = 1'b0;
	reg sys_rst = 1'b1;
	reg [7:0] awaddr = 8'h00, araddr = 8'h00;
	reg [31:0] wdata = 32'h0;
	reg [3:0] wstrb = 4'hF;
	reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	reg power_good = 1'b1, brownout = 1'b0, wdt_int_en = 1'b1, gie = 1'b1;
	reg adc_busy = 1'b0, rc_sel = 1'b0, wdt_ext = 1'b0;
	reg [1:0] ext_en = 2'h3;
	wire awready, wready, bvalid, arready, rvalid, rst_n, irq, kbd, adc_done;
	wire cpu_en, per_en, rc_en, freeze, core_rst, wdt_flag;
	wire [1:0] bresp, rresp, ext_n;
	wire [31:0] rdata;
	wire [15:0] rst_pc;
	wire [7:0] rst_sp, rst_port;
	reg [31:0] d;
	reg [1:0] r, b;
	integer num_errors = 0, checked = 0, cyc = 0, n;

	always #2 clk = ~clk;

	pmrc_top #(.POR_DELAY_CLKS(4), .WDT_INTERVAL(16), .WDT_CNT_W(20)) uut (
		.CLK(clk), .SYS_RST(sys_rst),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.RST_N_PIN(rst_n), .POWER_GOOD(power_good), .BROWNOUT_DET(brownout),
		.IRQ_PENDING(irq), .WDT_INT_EN(wdt_int_en), .GLOBAL_INT_ENABLE(gie),
		.EXT_INT_N(ext_n), .EXT_INT_EN(ext_en), .KEYPAD_INTERRUPT(kbd),
		.ADC_BUSY(adc_busy), .ADC_DONE(adc_done), .RC_CLK_SEL(rc_sel),
		.WDT_CLK_EXT(wdt_ext), .CPU_CLK_EN(cpu_en), .PERIPH_CLK_EN(per_en),
		.RC_CLK_EN(rc_en), .PORT_FREEZE(freeze), .WAKE_ISR(), .CORE_RST(core_rst),
		.WDT_TIMEOUT_FLAG(wdt_flag), .RESET_PC(rst_pc), .RESET_SP(rst_sp),
		.RESET_PORT(rst_port));

	pmrc_wake_src p (.clk(clk), .rst_n(rst_n), .ext_n(ext_n), .irq(irq),
		.kbd(kbd), .adc_done(adc_done));

	// ----
	// bus and check tasks
	// ----
	task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		begin
			checked = checked + 1;
			if (g !== e) begin
				num_errors = num_errors + 1;
				$display("ERROR %0s expected %h seen %h", nm, e, g);
			end
		end
	endtask

	task wr(input [7:0] a, input [7:0] v);
		begin
			@(posedge clk);
			awaddr <= a;
			wdata <= {24'h000000, v};
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			do begin
				@(posedge clk);
				if (awready) awvalid <= 1'b0;
				if (wready) wvalid <= 1'b0;
			end while (bvalid !== 1'b1);
			bready <= 1'b0;
			b = bresp;
		end
	endtask

	task rd(input [7:0] a);
		begin
			@(posedge clk);
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
			do begin
				@(posedge clk);
				if (arready) arvalid <= 1'b0;
			end while (rvalid !== 1'b1);
			rready <= 1'b0;
			d = rdata;
			r = rresp;
		end
	endtask

	task rdc(input string nm, input [7:0] a, input [7:0] m, input [7:0] e);
		begin
			rd(a);
			cmp(nm, {24'h0, e}, d & {24'h0, m});
			cmp("rresp", `PMRC_RESP_OKAY, r);
		end
	endtask

	task wait_rst(input v);
		begin
			n = 0;
			while (core_rst !== v && n < 200) begin
				@(posedge clk);
				n = n + 1;
			end
			cmp("core_rst", v, core_rst);
		end
	endtask

	task settle;
		repeat (3) @(posedge clk);
	endtask

	task tally_and_finish;
		begin
			$display("comparisons %0d mismatches %0d", checked, num_errors);
			if (num_errors == 0 && checked > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask

	// whole run is under two thousand cycles
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			num_errors = num_errors + 1;
			tally_and_finish;
		end
	end

	// ----
	// scenarios
	// ----
	initial begin
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		wait_rst(0);
		cmp("reset_pc", 16'h0000, rst_pc);
		cmp("reset_sp", 8'h07, rst_sp);
		cmp("reset_port", 8'hFF, rst_port);
		rdc("por_flag", `PMRC_AUX_OFF, 8'h02, 8'h02);
		rdc("watchdog_control_por", `PMRC_WATCHDOG_CONTROL_OFF, 8'hFF, 8'h00);
		wr(`PMRC_AUX_OFF, 8'h04);
		cmp("aux_bresp", `PMRC_RESP_OKAY, b);
		rdc("por_clear", `PMRC_AUX_OFF, 8'h02, 8'h00);
		rd(8'h10);
		cmp("unmapped_resp", `PMRC_RESP_SLVERR, r);
		cmp("unmapped_data", 32'h0, d);
		wr(8'h10, 8'hFF);
		cmp("unmapped_bresp", `PMRC_RESP_SLVERR, b);
		// lane 0 off: the write must be dropped
		wstrb <= 4'h0;
		wr(`PMRC_POWER_CONTROL_REG_OFF, 8'h01);
		wstrb <= 4'hF;
		rdc("strb_off", `PMRC_POWER_CONTROL_REG_OFF, 8'h03, 8'h00);
		wr(`PMRC_POWER_CONTROL_REG_OFF, 8'h01);
		settle;
		cmp("idle_cpu_clk", 0, cpu_en);
		cmp("idle_periph", 1, per_en);
		p.pulse(0, 2);
		settle;
		cmp("idle_wake", 1, cpu_en);
		rdc("idle_bit", `PMRC_POWER_CONTROL_REG_OFF, 8'h03, 8'h00);
		wr(`PMRC_POWER_CONTROL_REG_OFF, 8'h02);
		settle;
		cmp("pd_periph", 0, per_en);
		cmp("pd_rc_clk", 1, rc_en);
		p.pulse(1, 2);
		settle;
		cmp("ext_wake", 1, per_en);
		adc_busy <= 1'b1;
		rc_sel <= 1'b1;
		for (n = 2; n < 4; n = n + 1) begin
			wr(`PMRC_POWER_CONTROL_REG_OFF, 8'h02);
			settle;
			p.pulse(n, 2);
			settle;
			cmp("pd_wake", 1, per_en);
		end
		adc_busy <= 1'b0;
		gie <= 1'b0;
		wr(`PMRC_POWER_CONTROL_REG_OFF, 8'h02);
		p.pulse(1, 2);
		settle;
		cmp("gie_off", 0, per_en);
		p.pin_low(8);
		wait_rst(1);
		gie <= 1'b1;
		wait_rst(0);
		rdc("pin_por", `PMRC_AUX_OFF, 8'h02, 8'h00);
		rdc("pin_watchdog_reset_cause_flag", `PMRC_WATCHDOG_CONTROL_OFF, 8'h04, 8'h00);
		rdc("pd_ended", `PMRC_POWER_CONTROL_REG_OFF, 8'h03, 8'h00);
		p.pin_low(3);
		settle;
		cmp("short_pin", 0, core_rst);
		wr(`PMRC_WATCHDOG_CONTROL_OFF, 8'h82);
		wait_rst(0);
		while (wdt_flag !== 1'b1 && n < 400) begin
			@(posedge clk);
			n = n + 1;
		end
		rdc("watchdog_timeout_flag", `PMRC_WATCHDOG_CONTROL_OFF, 8'h08, 8'h08);
		n = 0;
		while (core_rst !== 1'b1 && n < 700) begin
			@(posedge clk);
			n = n + 1;
		end
		cmp("wdt_delay", 1, n > 490 && n < 515);
		wait_rst(0);
		rdc("wdt_cause", `PMRC_WATCHDOG_CONTROL_OFF, 8'h06, 8'h04);
		wr(`PMRC_WATCHDOG_CONTROL_OFF, 8'h00);
		// externally clocked watchdog must stay frozen in power-down
		wdt_ext <= 1'b1;
		wr(`PMRC_WATCHDOG_CONTROL_OFF, 8'h83);
		wr(`PMRC_POWER_CONTROL_REG_OFF, 8'h02);
		repeat (600) @(posedge clk);
		cmp("wdt_ext_rst", 0, core_rst);
		cmp("wdt_ext_flag", 0, wdt_flag);
		p.pulse(1, 2);
		wr(`PMRC_WATCHDOG_CONTROL_OFF, 8'h00);
		wdt_ext <= 1'b0;
		settle;
		cmp("pd_wake_ext", 1, per_en);
		wr(`PMRC_AUX_OFF, 8'h01);
		wait_rst(1);
		wait_rst(0);
		brownout <= 1'b1;
		wait_rst(1);
		brownout <= 1'b0;
		wait_rst(0);
		power_good <= 1'b0;
		wait_rst(1);
		power_good <= 1'b1;
		wait_rst(0);
		rdc("por_again", `PMRC_AUX_OFF, 8'h02, 8'h02);
		tally_and_finish;
	end
endmodule // pmrc_top_test

bind pmrc_top pmrc_checker chk (.CLK(CLK), .SYS_RST(SYS_RST), .RST_N_PIN(RST_N_PIN),
	.IRQ_PENDING(IRQ_PENDING), .GLOBAL_INT_ENABLE(GLOBAL_INT_ENABLE),
	.EXT_INT_N(EXT_INT_N), .EXT_INT_EN(EXT_INT_EN), .CPU_CLK_EN(CPU_CLK_EN),
	.PERIPH_CLK_EN(PERIPH_CLK_EN), .RC_CLK_EN(RC_CLK_EN), .PORT_FREEZE(PORT_FREEZE),
	.WAKE_ISR(WAKE_ISR), .CORE_RST(CORE_RST), .RESET_PC(RESET_PC), .RESET_SP(RESET_SP),
	.RESET_PORT(RESET_PORT));
